// [core/mseq_pkg.sv]
package mseq_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int STEP_64US_NS = 64_000;
    localparam int STEP_4MS_NS = 4_100_000;
    localparam int STEP_262MS_NS = 262_000_000;
    localparam int CYC_64US = (STEP_64US_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int CYC_4MS = (STEP_4MS_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int CYC_262MS = (STEP_262MS_NS / 1000) * (CLK_HZ / 1_000_000);

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_TIMER = 4'h2;
    localparam logic [3:0] ADDR_RXCFG = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    localparam int CTRL_LAUNCH = 0;
    localparam int CTRL_HALT = 1;
    localparam int CTRL_RESTART = 2;

    // Chip mode codes
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STDBY = 3'h1;
    localparam logic [2:0] MODE_FSRX = 3'h4;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h5;

    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [19:0] TIMER_RESET = 20'h00000;
    localparam logic [9:0] RXCFG_RESET = 10'h000;

    typedef enum {
        SQ_IDLE, SQ_WAITFIFO, SQ_LOWPOWER, SQ_TX, SQ_RX, SQ_PKTRX, SQ_RXRESTART
    } mseq_state_t;

    typedef struct packed {
        logic idleSleep;
        logic [1:0] launchExit;
        logic lowPowerExit;
        logic idleExit;
        logic txExit;
        logic [2:0] rxExit;
        logic [1:0] rxTimeoutExit;
        logic [2:0] pktReceivedExit;
        logic lowPowerSleep;
        logic crcOn;
    } mseq_cfg_t;

    typedef struct packed {
        logic [1:0] firstStep;
        logic [1:0] secondStep;
        logic [7:0] firstMult;
        logic [7:0] secondMult;
    } mseq_timer_t;

    typedef struct packed {
        logic fifoLevel;
        logic fifoDrained;
        logic txDone;
        logic rxPayload;
        logic checkPass;
        logic badCheckAutoFlush;
        logic strengthDetect;
        logic syncMatch;
        logic preambleFound;
        logic strengthTimeout;
        logic preambleTimeout;
        logic syncTimeout;
    } mseq_evt_t;
endpackage : mseq_pkg

// [core/mseq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module mseq_sequencer
    import mseq_pkg::*;
#(
    parameter int STEP1_CYC = CYC_64US,
    parameter int STEP2_CYC = CYC_4MS,
    parameter int STEP3_CYC = CYC_262MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clockEnable,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // Radio events, same clock domain, one-cycle pulses
    input wire mseq_evt_t events,
    input wire logic [7:0] strengthDb,
    input wire logic modeSettledFlag,
    input wire logic [2:0] chipModeNow,
    // Chip control
    output logic [2:0] chipModeReq,
    output logic chipModeLoad,
    output logic rxRestart,
    output logic firstTimerEvent,
    output logic secondTimerEvent
);
    mseq_cfg_t cfg;
    mseq_timer_t tmr;
    logic collisionRestartEnable;
    logic [7:0] collisionThreshold;
    mseq_state_t state;
    mseq_state_t next_state;
    logic [2:0] initialMode;
    logic [7:0] strengthBase;
    logic timerActive;
    logic timerPhase;
    logic [27:0] stepCnt;
    logic [7:0] multCnt;
    logic goLowSel;
    logic goOff;
    logic [2:0] next_mode;
    logic next_load;

    function automatic logic [27:0] step_cycles(input logic [1:0] sel);
        unique case (sel)
            2'h1: step_cycles = 28'(STEP1_CYC);
            2'h2: step_cycles = 28'(STEP2_CYC);
            2'h3: step_cycles = 28'(STEP3_CYC);
            default: step_cycles = 28'h0000000;
        endcase
    endfunction : step_cycles

    wire wrCtrl = regWrite && regAddr == ADDR_CTRL;
    wire launchCmd = wrCtrl && regWrData[CTRL_LAUNCH];
    wire haltCmd = wrCtrl && regWrData[CTRL_HALT];
    wire userRestart = wrCtrl && regWrData[CTRL_RESTART] && modeSettledFlag;
    wire chipLow = chipModeNow == MODE_SLEEP || chipModeNow == MODE_STDBY;
    wire launchOk = launchCmd && !haltCmd && state == SQ_IDLE && chipLow;
    wire rx_timeout_event = events.strengthTimeout || events.preambleTimeout
        || events.syncTimeout;
    wire badPacket = cfg.rxExit == 3'h3 && cfg.crcOn && !events.badCheckAutoFlush
        && events.rxPayload && !events.checkPass;
    wire inRx = state == SQ_RX || state == SQ_PKTRX || state == SQ_RXRESTART;
    wire [8:0] strengthRise = {1'b0, strengthDb} - {1'b0, strengthBase};
    wire collision = collisionRestartEnable && inRx && !strengthRise[8]
        && strengthRise[7:0] > collisionThreshold;
    wire [1:0] curStep = timerPhase ? tmr.secondStep : tmr.firstStep;
    wire [7:0] curMult = timerPhase ? tmr.secondMult : tmr.firstMult;
    wire stepDone = stepCnt == 28'h0000001;
    wire intervalDone = timerActive && stepDone && multCnt <= 8'h01;
    wire t1Fire = intervalDone && !timerPhase;
    wire t2Fire = intervalDone && timerPhase;
    wire [1:0] nextStepSel = timerPhase ? tmr.firstStep : tmr.secondStep;

    // Transition logic
    always_comb begin
        next_state = state;
        goLowSel = 1'b0;
        goOff = 1'b0;
        if (launchOk) begin
            unique case (cfg.launchExit)
                2'h0: goLowSel = 1'b1;
                2'h1: next_state = SQ_RX;
                2'h2: next_state = SQ_TX;
                2'h3: next_state = SQ_WAITFIFO;
            endcase
        end else begin
            unique case (state)
                SQ_IDLE: begin
                    if (t1Fire && timerActive && initialMode != 3'h7) begin
                        next_state = cfg.idleExit ? SQ_RX : SQ_TX;
                    end
                end
                SQ_WAITFIFO: begin
                    if (events.fifoLevel) begin
                        next_state = SQ_TX;
                    end
                end
                SQ_LOWPOWER: begin
                    if (t1Fire) begin
                        next_state = cfg.idleExit ? SQ_RX : SQ_TX;
                    end
                end
                SQ_TX: begin
                    if (events.txDone) begin
                        if (cfg.txExit) begin
                            next_state = SQ_RX;
                        end else begin
                            goLowSel = 1'b1;
                        end
                    end
                end
                SQ_RX: begin
                    if (t2Fire) begin
                        goLowSel = 1'b1;
                    end else if (rx_timeout_event || badPacket) begin
                        unique case (cfg.rxTimeoutExit)
                            2'h0: next_state = SQ_RXRESTART;
                            2'h1: next_state = SQ_TX;
                            2'h2: goLowSel = 1'b1;
                            2'h3: goOff = 1'b1;
                        endcase
                    end else begin
                        unique case (cfg.rxExit)
                            3'h1: if (events.rxPayload) next_state = SQ_PKTRX;
                            3'h2: if (events.rxPayload) goLowSel = 1'b1;
                            3'h3: if (events.checkPass) next_state = SQ_PKTRX;
                            3'h4: if (events.strengthDetect) goOff = 1'b1;
                            3'h5: if (events.syncMatch) goOff = 1'b1;
                            3'h6: if (events.preambleFound) goOff = 1'b1;
                            default: next_state = SQ_RX;
                        endcase
                    end
                end
                SQ_PKTRX: begin
                    unique case (cfg.pktReceivedExit)
                        3'h0: goOff = 1'b1;
                        3'h1: if (events.fifoDrained) next_state = SQ_TX;
                        3'h2: goLowSel = 1'b1;
                        3'h3: next_state = SQ_RXRESTART;
                        3'h4: next_state = SQ_RX;
                        default: goOff = 1'b1;
                    endcase
                end
                SQ_RXRESTART: next_state = SQ_RX;
            endcase
            if (goLowSel) begin
                next_state = cfg.lowPowerExit ? SQ_LOWPOWER : SQ_IDLE;
                goOff = !cfg.lowPowerExit;
            end
            if (goOff) begin
                next_state = SQ_IDLE;
            end
        end
        if (haltCmd) begin
            next_state = SQ_IDLE;
        end
    end

    // Chip mode request, issued on state entry and, with lowPowerExit set, on a launch with launchExit 0, which stays in SQ_IDLE
    always_comb begin
        next_mode = chipModeReq;
        next_load = 1'b0;
        if (launchOk && cfg.launchExit == 2'h0 && cfg.lowPowerExit) begin
            next_load = 1'b1;
            next_mode = cfg.idleSleep ? MODE_SLEEP : MODE_STDBY;
        end else if (goOff && !haltCmd) begin
            next_load = 1'b1;
            next_mode = goLowSel ? initialMode : MODE_SLEEP;
        end else if (next_state != state || state == SQ_PKTRX && next_state == SQ_RXRESTART) begin
            next_load = 1'b1;
            unique case (next_state)
                SQ_TX: next_mode = MODE_TX;
                SQ_RX: next_mode = MODE_RX;
                SQ_RXRESTART: next_mode = cfg.pktReceivedExit == 3'h3 ? MODE_FSRX : MODE_RX;
                SQ_LOWPOWER: next_mode = cfg.idleSleep ? MODE_SLEEP : MODE_STDBY;
                default: next_load = 1'b0;
            endcase
        end
    end

    // Sequencer state and outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= SQ_IDLE;
            chipModeReq <= MODE_STDBY;
            chipModeLoad <= 1'b0;
            rxRestart <= 1'b0;
            initialMode <= MODE_STDBY;
            strengthBase <= 8'h00;
        end else if (clockEnable) begin
            state <= next_state;
            chipModeReq <= next_mode;
            chipModeLoad <= next_load;
            rxRestart <= userRestart || collision || next_state == SQ_RXRESTART;
            if (launchOk) begin
                initialMode <= chipModeNow;
            end
            strengthBase <= (collision || !inRx) ? strengthDb : 
                (strengthDb < strengthBase ? strengthDb : strengthBase);
        end
    end

    // Timer chain, independent of sequencer state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timerActive <= 1'b0;
            timerPhase <= 1'b0;
            stepCnt <= 28'h0000000;
            multCnt <= 8'h00;
            firstTimerEvent <= 1'b0;
            secondTimerEvent <= 1'b0;
        end else if (clockEnable) begin
            firstTimerEvent <= t1Fire;
            secondTimerEvent <= t2Fire;
            if (launchOk) begin
                timerPhase <= 1'b0;
                timerActive <= tmr.firstStep != 2'h0;
                stepCnt <= step_cycles(tmr.firstStep);
                multCnt <= tmr.firstMult;
            end else if (haltCmd) begin
                timerActive <= 1'b0;
            end else if (intervalDone) begin
                timerPhase <= !timerPhase;
                timerActive <= nextStepSel != 2'h0;
                stepCnt <= step_cycles(nextStepSel);
                multCnt <= timerPhase ? tmr.firstMult : tmr.secondMult;
            end else if (timerActive) begin
                if (stepDone) begin
                    stepCnt <= step_cycles(curStep);
                    multCnt <= multCnt - 8'h01;
                end else begin
                    stepCnt <= stepCnt - 28'h0000001;
                end
            end
        end
    end

    // Register file
    wire [31:0] rdMux = regAddr == ADDR_CFG ? {16'h0000, cfg} :
        regAddr == ADDR_TIMER ? {12'h000, tmr} :
        regAddr == ADDR_RXCFG ? {22'h000000, collisionThreshold, 1'b0, collisionRestartEnable} :
        regAddr == ADDR_STATUS ? {24'h000000, initialMode, timerPhase, timerActive,
            3'(state)} : 32'h00000000;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= mseq_cfg_t'(CFG_RESET);
            tmr <= mseq_timer_t'(TIMER_RESET);
            collisionRestartEnable <= 1'b0;
            collisionThreshold <= 8'h00;
            regRdData <= 32'h00000000;
        end else if (clockEnable) begin
            if (regWrite && regAddr == ADDR_CFG) cfg <= mseq_cfg_t'(regWrData[15:0]);
            if (regWrite && regAddr == ADDR_TIMER) tmr <= mseq_timer_t'(regWrData[19:0]);
            if (regWrite && regAddr == ADDR_RXCFG) begin
                collisionRestartEnable <= regWrData[0];
                collisionThreshold <= regWrData[9:2];
            end
            regRdData <= regRead ? rdMux : 32'h00000000;
        end
    end
endmodule : mseq_sequencer
`default_nettype wire

// [dv/mseq_sequencer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mseq_sequencer_props
    import mseq_pkg::*;
#(
    parameter int STEP1_CYC = 4,
    parameter int STEP2_CYC = 8,
    parameter int STEP3_CYC = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clockEnable,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    // Radio side
    input wire mseq_evt_t events,
    input wire logic [7:0] strengthDb,
    input wire logic modeSettledFlag,
    input wire logic [2:0] chipModeNow,
    input wire logic [2:0] chipModeReq,
    input wire logic chipModeLoad,
    input wire logic rxRestart,
    input wire logic firstTimerEvent,
    input wire logic secondTimerEvent
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic ctrlWr = regWrite && clockEnable && regAddr == ADDR_CTRL;
    sequence cfgWrite;
        regWrite && clockEnable && regAddr == ADDR_CFG;
    endsequence
    sequence cfgReadLater;
        clockEnable && !regWrite ##1 regRead && clockEnable && regAddr == ADDR_CFG;
    endsequence
    // Shortest interval is one step of the smallest resolution
    sequence timersQuiet;
        !(firstTimerEvent || secondTimerEvent) [*3];
    endsequence
    read_idle_zero_a: assert property (clockEnable && !regRead |=> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (clockEnable && regRead && regAddr > ADDR_STATUS
        |=> regRdData == 32'h0) else $error("unmapped read not zero");
    cfg_readback_a: assert property (cfgWrite ##1 cfgReadLater
        |=> regRdData[15:0] == $past(regWrData[15:0], 3)) else $error("config readback");
    enable_freeze_a: assert property (!clockEnable
        |=> $stable(chipModeReq) && $stable(regRdData)) else $error("frozen state moved");
    halt_no_mode_a: assert property (ctrlWr && regWrData[CTRL_HALT] |=> !chipModeLoad)
        else $error("halt requested a mode");
    user_restart_a: assert property (ctrlWr && regWrData[CTRL_RESTART] && modeSettledFlag
        |=> rxRestart) else $error("user restart lost");
    first_spacing_a: assert property (firstTimerEvent |=> timersQuiet)
        else $error("timer event too soon after first");
    second_spacing_a: assert property (secondTimerEvent |=> timersQuiet)
        else $error("timer event too soon after second");
endmodule : mseq_sequencer_props
bind mseq_sequencer mseq_sequencer_props #(
    .STEP1_CYC(STEP1_CYC), .STEP2_CYC(STEP2_CYC), .STEP3_CYC(STEP3_CYC)
) u_props (
    .clock(clock), .arst_n(arst_n), .clockEnable(clockEnable), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .events(events), .strengthDb(strengthDb), .modeSettledFlag(modeSettledFlag),
    .chipModeNow(chipModeNow), .chipModeReq(chipModeReq), .chipModeLoad(chipModeLoad),
    .rxRestart(rxRestart), .firstTimerEvent(firstTimerEvent),
    .secondTimerEvent(secondTimerEvent)
);
`default_nettype wire

// [dv/mseq_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module mseq_sequencer_tb_top
    import mseq_pkg::*;
;
    localparam int STP [4] = '{0, 4, 8, 16};
    localparam logic [2:0] LST [4] = '{3'd0, 3'd4, 3'd3, 3'd1};
    localparam logic [2:0] LMODE [4] = '{MODE_SLEEP, MODE_RX, MODE_TX, MODE_STDBY};
    // Launch, rx, timeout, tx, packet exits; event; final state
    localparam logic [25:0] ROWS [18] = '{
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd1, 12'h100, 3'd3},
        {2'd1, 3'd3, 2'd3, 1'b0, 3'd4, 12'h080, 3'd4},
        {2'd1, 3'd3, 2'd1, 1'b0, 3'd0, 12'h100, 3'd3},
        {2'd1, 3'd3, 2'd3, 1'b0, 3'd0, 12'h140, 3'd4},
        {2'd1, 3'd2, 2'd3, 1'b0, 3'd0, 12'h100, 3'd0},
        {2'd1, 3'd4, 2'd3, 1'b0, 3'd0, 12'h020, 3'd0},
        {2'd1, 3'd5, 2'd3, 1'b0, 3'd0, 12'h010, 3'd0},
        {2'd1, 3'd6, 2'd3, 1'b0, 3'd0, 12'h008, 3'd0},
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd0, 12'h004, 3'd0},
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd0, 12'h002, 3'd0},
        {2'd1, 3'd1, 2'd1, 1'b0, 3'd0, 12'h001, 3'd3},
        {2'd1, 3'd1, 2'd0, 1'b0, 3'd0, 12'h004, 3'd4},
        {2'd1, 3'd1, 2'd2, 1'b0, 3'd0, 12'h004, 3'd0},
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd0, 12'h100, 3'd0},
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd2, 12'h100, 3'd0},
        {2'd1, 3'd1, 2'd3, 1'b0, 3'd3, 12'h100, 3'd4},
        {2'd2, 3'd1, 2'd3, 1'b1, 3'd0, 12'h200, 3'd4},
        {2'd2, 3'd1, 2'd3, 1'b0, 3'd0, 12'h200, 3'd0}};
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic clockEnable = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData, rdVal;
    mseq_evt_t events = '0;
    logic [7:0] strengthDb = 8'h32;
    logic modeSettledFlag = 1'b1;
    logic [2:0] chipModeNow = MODE_STDBY;
    logic [2:0] chipModeReq;
    logic chipModeLoad, rxRestart, firstTimerEvent, secondTimerEvent;
    mseq_cfg_t cfg = '0;
    int n_mismatch = 0;
    int compares = 0;
    int nRestart = 0;
    int nSecond = 0;
    int cyc = 0;
    mseq_sequencer #(.STEP1_CYC(4), .STEP2_CYC(8), .STEP3_CYC(16)) dut (
        .clock(clock), .arst_n(arst_n), .clockEnable(clockEnable), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .events(events), .strengthDb(strengthDb), .modeSettledFlag(modeSettledFlag),
        .chipModeNow(chipModeNow), .chipModeReq(chipModeReq), .chipModeLoad(chipModeLoad),
        .rxRestart(rxRestart), .firstTimerEvent(firstTimerEvent),
        .secondTimerEvent(secondTimerEvent));
    initial begin
        forever #10 clock = ~clock;
    end
    // Radio stand-in: chip mode follows each request one cycle later
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (chipModeLoad === 1'b1) chipModeNow <= chipModeReq;
        if (rxRestart === 1'b1) nRestart <= nRestart + 1;
        if (secondTimerEvent === 1'b1) nSecond <= nSecond + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rdVal = regRdData;
    endtask : rd
    task automatic chkState(input logic [2:0] exp);
        rd(ADDR_STATUS);
        chk({29'h0, rdVal[2:0]}, {29'h0, exp});
    endtask : chkState
    task automatic pulse(input logic [11:0] e);
        @(posedge clock);
        events <= mseq_evt_t'(e);
        @(posedge clock);
        events <= '0;
        repeat (3) @(posedge clock);
    endtask : pulse
    task automatic start(input logic [2:0] mode);
        wr(ADDR_CTRL, 32'h2);
        chkState(3'd0);
        chipModeNow <= mode;
        wr(ADDR_CFG, {16'h0, cfg});
        wr(ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clock);
    endtask : start
    task automatic waitEvt(input bit second, output int at);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge clock);
            #1;
            if ((second ? secondTimerEvent : firstTimerEvent) === 1'b1) break;
        end
        chk({31'h0, i < 600}, 32'h1);
        at = cyc;
    endtask : waitEvt
    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #1_000_000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        int t1, t2, t3;
        logic [25:0] row;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk({29'h0, chipModeReq}, {29'h0, MODE_STDBY});
        rd(ADDR_TIMER);
        chk(rdVal, {12'h0, TIMER_RESET});
        rd(ADDR_RXCFG);
        chk(rdVal, {22'h0, RXCFG_RESET});
        rd(4'hc);
        chk(rdVal, 32'h0);
        wr(ADDR_CFG, 32'h0000a5c3);
        rd(ADDR_CFG);
        chk(rdVal, 32'h0000a5c3);
        clockEnable <= 1'b0;
        wr(ADDR_CFG, 32'h0);
        clockEnable <= 1'b1;
        rd(ADDR_CFG);
        chk(rdVal, 32'h0000a5c3);
        cfg = '0;
        cfg.crcOn = 1'b1;
        cfg.idleSleep = 1'b1;
        cfg.lowPowerExit = 1'b1;
        for (int e = 0; e < 4; e++) begin
            cfg.launchExit = e[1:0];
            start(MODE_STDBY);
            chkState(LST[e]);
            chk({29'h0, chipModeNow}, {29'h0, LMODE[e]});
        end
        pulse(12'h800);
        chkState(3'd3);
        for (int i = 0; i < 3; i++) begin
            {cfg.launchExit, cfg.rxExit} = {2'd1, 3'd2};
            {cfg.lowPowerExit, cfg.idleSleep} = {i > 0, i > 1};
            start(i == 0 ? MODE_SLEEP : MODE_STDBY);
            pulse(12'h100);
            chk({29'h0, chipModeNow}, {29'h0, i == 1 ? MODE_STDBY : MODE_SLEEP});
        end
        // Later scenarios expect off exits, not the low-power state
        cfg.lowPowerExit = 1'b0;
        foreach (ROWS[r]) begin
            row = ROWS[r];
            {cfg.launchExit, cfg.rxExit, cfg.rxTimeoutExit, cfg.txExit} = row[25:18];
            cfg.pktReceivedExit = row[17:15];
            t1 = nRestart;
            start(MODE_STDBY);
            pulse(row[14:3]);
            pulse(12'h400);
            chkState(row[2:0]);
            chk(32'(nRestart - t1), {31'h0, row[20:19] == 2'd0 || row[17:15] == 3'd3});
        end
        wr(ADDR_RXCFG, 32'h15);
        cfg.launchExit = 2'd1;
        strengthDb <= 8'd50;
        start(MODE_STDBY);
        t1 = nRestart;
        strengthDb <= 8'd55;
        repeat (4) @(posedge clock);
        strengthDb <= 8'd56;
        repeat (4) @(posedge clock);
        chk(32'(nRestart - t1), 32'h1);
        wr(ADDR_RXCFG, 32'h14);
        strengthDb <= 8'd40;
        repeat (4) @(posedge clock);
        strengthDb <= 8'd70;
        modeSettledFlag <= 1'b0;
        wr(ADDR_CTRL, 32'h4);
        modeSettledFlag <= 1'b1;
        wr(ADDR_CTRL, 32'h4);
        repeat (3) @(posedge clock);
        chk(32'(nRestart - t1), 32'h2);
        wr(ADDR_CTRL, 32'h2);
        chipModeNow <= MODE_RX;
        wr(ADDR_CTRL, 32'h1);
        chkState(3'd0);
        {cfg.launchExit, cfg.idleExit} = {2'd0, 1'b1};
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_TIMER, 32'h0);
            repeat (40) @(posedge clock);
            wr(ADDR_TIMER, {12'h0, s[1:0], s[1:0], 8'h02, 8'h01});
            start(MODE_STDBY);
            waitEvt(1'b0, t1);
            chkState(3'd4);
            waitEvt(1'b1, t2);
            chkState(3'd0);
            waitEvt(1'b0, t3);
            chk(32'(t2 - t1), 32'(STP[s]));
            chk(32'(t3 - t2), 32'(2 * STP[s]));
        end
        wr(ADDR_TIMER, 32'h00040101);
        start(MODE_STDBY);
        t1 = nSecond;
        repeat (100) @(posedge clock);
        chk(32'(nSecond - t1), 32'h0);
        complete_run();
    end
endmodule : mseq_sequencer_tb_top
`default_nettype wire
